/* File: logic/uart_fifo_irq.v */
`timescale 1ns/10ps
`include "uart_irq_regs.vh"
module uart_fifo_irq (
    // Clock and reset.
    input wire sys_clk,
    input wire nrst,
    // Register port from the serial slave logic.
    input wire [3:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Enhanced functions write enable.
    input wire enh_en,
    // FIFO levels and data strobes.
    input wire [6:0] rx_level,
    input wire [6:0] tx_space,
    input wire tx_write,
    // Interrupt condition levels from the rest of the channel.
    input wire line_err,
    input wire rx_timeout,
    input wire modem_event,
    input wire pin_change,
    input wire xoff_event,
    input wire cts_event,
    input wire rts_event,
    // Control outputs.
    output reg fifo_en,
    output reg rx_fifo_clr,
    output reg tx_fifo_clr,
    output reg [6:0] rx_trig_level,
    output reg [6:0] tx_trig_level,
    output reg sleep_en,
    output reg [7:0] irq_enable_out,
    output reg irq_n
);

    localparam ST_IDLE = 2'b01;
    localparam ST_CLR = 2'b10;

    // With the FIFOs off a single holding location is used, so one character already asks for service.
    // The transmit side then waits for a completely empty FIFO instead.
    function [6:0] rx_trig;
        input [1:0] sel;
        input en;
        begin
            if (!en)
            begin
                rx_trig = `RX_TRIG_NOFIFO;
            end
            else
            begin
                case (sel)
                    2'h0: rx_trig = `RX_TRIG_0;
                    2'h1: rx_trig = `RX_TRIG_1;
                    2'h2: rx_trig = `RX_TRIG_2;
                    default: rx_trig = `RX_TRIG_3;
                endcase
            end
        end
    endfunction

    function [6:0] tx_trig;
        input [1:0] sel;
        input en;
        begin
            if (!en)
            begin
                tx_trig = `FIFO_DEPTH;
            end
            else
            begin
                case (sel)
                    2'h0: tx_trig = `TX_TRIG_0;
                    2'h1: tx_trig = `TX_TRIG_1;
                    2'h2: tx_trig = `TX_TRIG_2;
                    default: tx_trig = `TX_TRIG_3;
                endcase
            end
        end
    endfunction

    // The clear sequencers count the same clock that runs the FIFO level logic.
    reg [7:0] ier_q;
    reg [7:0] ier_d;
    reg en_q;
    reg [1:0] rx_sel_q;
    reg [1:0] tx_sel_q;
    reg [1:0] rx_st_q;
    reg [1:0] tx_st_q;
    reg [1:0] rx_cnt_q;
    reg [1:0] tx_cnt_q;
    reg tx_above_q;
    reg tx_pend_q;
    reg tx_pend_d;
    reg [5:0] id_d;
    reg any_d;
    reg [7:0] rdata_d;

    // Control and identification share one address; the direction of the access tells them apart.
    wire wr_ier = reg_wr && (reg_addr == `ADDR_IRQ_ENABLE);
    wire wr_fcr = reg_wr && (reg_addr == `ADDR_FIFO_CTRL);
    wire rd_iir = reg_rd && (reg_addr == `ADDR_IRQ_IDENT);
    wire [6:0] rx_thr = rx_trig(rx_sel_q, en_q);
    wire [6:0] tx_thr = tx_trig(tx_sel_q, en_q);
    wire tx_above = (tx_space >= tx_thr);
    wire tx_busy = tx_st_q[1];

    // Enhanced bits hold their value unless the enhanced enable allows a write.
    always @*
    begin
        ier_d = ier_q;
        if (wr_ier)
        begin
            ier_d[3:0] = reg_wdata[3:0];
            if (enh_en)
            begin
                ier_d[7:4] = reg_wdata[7:4];
            end
        end
    end

    // Receive data and timeout share enable bit 0, as both are served by one receive routine.
    // Pin change is already qualified outside this block, so it is not gated here.
    // Receive data is held off while its FIFO is being cleared, since the level is then meaningless.
    wire src_line = line_err && ier_q[`IER_LINE_BIT];
    wire src_tmo = rx_timeout && ier_q[`IER_RX_BIT];
    wire src_rx = (rx_level >= rx_thr) && (rx_level != 7'h00) && ier_q[`IER_RX_BIT] && !rx_st_q[1];
    wire src_tx = tx_pend_q && ier_q[`IER_TX_BIT];
    wire src_modem = modem_event && ier_q[`IER_MODEM_BIT];
    wire src_pin = pin_change;
    wire src_xoff = xoff_event && ier_q[`IER_XOFF_BIT];
    wire src_flow = (cts_event && ier_q[`IER_CTS_BIT]) || (rts_event && ier_q[`IER_RTS_BIT]);

    // Only the top pending source is encoded; others wait their turn.
    always @*
    begin
        any_d = 1'b1;
        if (src_line)
        begin
            id_d = `ID_LINE;
        end
        else if (src_tmo)
        begin
            id_d = `ID_TIMEOUT;
        end
        else if (src_rx)
        begin
            id_d = `ID_RX;
        end
        else if (src_tx)
        begin
            id_d = `ID_TX;
        end
        else if (src_modem)
        begin
            id_d = `ID_MODEM;
        end
        else if (src_pin)
        begin
            id_d = `ID_PIN;
        end
        else if (src_xoff)
        begin
            id_d = `ID_XOFF;
        end
        else if (src_flow)
        begin
            id_d = `ID_FLOW;
        end
        else
        begin
            id_d = 6'h00;
            any_d = 1'b0;
        end
    end

    // The transmit flag is armed only by a crossing of the threshold, so an enable write alone
    // cannot raise it. A clear in the same cycle as a new crossing loses to the crossing.
    always @*
    begin
        tx_pend_d = tx_pend_q;
        if (tx_write || (rd_iir && any_d && (id_d == `ID_TX)) || (wr_ier && !reg_wdata[`IER_TX_BIT]))
        begin
            tx_pend_d = 1'b0;
        end
        if (tx_above && !tx_above_q && !tx_busy && ier_q[`IER_TX_BIT])
        begin
            tx_pend_d = 1'b1;
        end
    end

    // The control location is write-only, so a read there returns identification.
    always @*
    begin
        rdata_d = 8'h00;
        if (reg_addr == `ADDR_IRQ_IDENT)
        begin
            // Bit 0 of the code slot carries the no-pending flag, so the code's own bit 0 is dropped.
            rdata_d = {en_q, en_q, id_d[5:1], !any_d};
        end
        else if (reg_addr == `ADDR_IRQ_ENABLE)
        begin
            rdata_d = ier_q;
        end
    end

    // A control write updates FIFO enable and receive trigger at once; the transmit trigger
    // is an enhanced function and keeps its old value without the enhanced enable.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ier_q <= `IRQ_ENABLE_RESET;
            en_q <= 1'b0;
            rx_sel_q <= 2'h0;
            tx_sel_q <= 2'h0;
            tx_above_q <= 1'b0;
            tx_pend_q <= 1'b0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            ier_q <= ier_d;
            tx_above_q <= tx_above;
            tx_pend_q <= tx_pend_d;
            if (reg_rd)
            begin
                reg_rdata <= rdata_d;
            end
            if (wr_fcr)
            begin
                en_q <= reg_wdata[`FCR_EN_BIT];
                rx_sel_q <= reg_wdata[`FCR_RX_TRIG_MSB:`FCR_RX_TRIG_LSB];
                if (enh_en)
                begin
                    tx_sel_q <= reg_wdata[`FCR_TX_TRIG_MSB:`FCR_TX_TRIG_LSB];
                end
            end
        end
    end

    // Each FIFO clear is a short sequence rather than a one-cycle pulse, so the level logic
    // outside sees the clear for the full minimum time on the reference clock.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_st_q <= ST_IDLE;
            rx_cnt_q <= 2'h0;
        end
        else
        begin
            case (rx_st_q)
                ST_IDLE:
                begin
                    if (wr_fcr && reg_wdata[`FCR_RX_RST_BIT])
                    begin
                        rx_st_q <= ST_CLR;
                        rx_cnt_q <= `FIFO_RST_CYCLES;
                    end
                end
                ST_CLR:
                begin
                    rx_cnt_q <= rx_cnt_q - 2'h1;
                    if (rx_cnt_q == 2'h1)
                    begin
                        rx_st_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    rx_st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // The transmit clear runs the same sequence. Because it counts the clock, a stopped clock
    // also stalls the clear, so it can never end early.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_st_q <= ST_IDLE;
            tx_cnt_q <= 2'h0;
        end
        else
        begin
            case (tx_st_q)
                ST_IDLE:
                begin
                    if (wr_fcr && reg_wdata[`FCR_TX_RST_BIT])
                    begin
                        tx_st_q <= ST_CLR;
                        tx_cnt_q <= `FIFO_RST_CYCLES;
                    end
                end
                ST_CLR:
                begin
                    tx_cnt_q <= tx_cnt_q - 2'h1;
                    if (tx_cnt_q == 2'h1)
                    begin
                        tx_st_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    tx_st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Outputs are registered copies; the clear strobes follow the sequencer by one cycle.
    always @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fifo_en <= 1'b0;
            rx_fifo_clr <= 1'b0;
            tx_fifo_clr <= 1'b0;
            rx_trig_level <= `RX_TRIG_NOFIFO;
            tx_trig_level <= `FIFO_DEPTH;
            sleep_en <= 1'b0;
            irq_enable_out <= `IRQ_ENABLE_RESET;
            irq_n <= 1'b1;
        end
        else
        begin
            fifo_en <= en_q;
            rx_fifo_clr <= rx_st_q[1];
            tx_fifo_clr <= tx_st_q[1];
            rx_trig_level <= rx_thr;
            tx_trig_level <= tx_thr;
            sleep_en <= ier_q[`IER_SLEEP_BIT];
            irq_enable_out <= ier_q;
            // The request pin is registered, so it follows the pending sources one cycle later.
            irq_n <= !any_d;
        end
    end

endmodule

/* File: logic/uart_irq_regs.vh */
// What this block does
// - Transmit interrupt is gated by enable bit 1, cleared at reset.
// - Receive data interrupt is gated by enable bit 0, cleared at reset.
// - Upper four enable bits change only while the enhanced bit is set.
// - Setting transmit enable again raises a transmit interrupt by itself only if a threshold crossing came in the same cycle as the write that cleared it.
// - FIFO control register is write-only; its location reads identification instead.
// - Receive trigger bits 7:6 select 8, 16, 56 or 60 characters.
// - Transmit trigger bits 5:4 select 8, 16, 32 or 56 free spaces.
// - Transmit trigger bits change only while the enhanced bit is set.
// - Transmit FIFO reset bit empties the transmit FIFO, then clears itself.
// - Receive FIFO reset bit empties the receive FIFO, then clears itself.
// - FIFO enable bit enables or disables both FIFOs; default zero.
// - A FIFO reset lasts at least two reference clock cycles.
// - Identification register is eight bits, read-only, prioritised source report.
// - Identification bits 7 and 6 both mirror the FIFO enable bit.
// - Identification bit 0 is zero while any interrupt is pending.
// - Codes: line error 000110, timeout 001100, receive 000100, transmit 000010, modem 000000.
// - Pin change reports 110000 at level 5, Xoff or special character 010000.
// - Flow pin rising to inactive reports 100000 at lowest level 7.
// - Interrupt request output is active whenever an enabled condition exists, except receive data or a transmit crossing while that FIFO is being cleared.
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH

`define ADDR_IRQ_ENABLE 4'h1
`define ADDR_FIFO_CTRL 4'h2
`define ADDR_IRQ_IDENT 4'h2

`define IRQ_ENABLE_RESET 8'h00
`define FIFO_CTRL_RESET 8'h00

`define IER_RX_BIT 0
`define IER_TX_BIT 1
`define IER_LINE_BIT 2
`define IER_MODEM_BIT 3
`define IER_SLEEP_BIT 4
`define IER_XOFF_BIT 5
`define IER_RTS_BIT 6
`define IER_CTS_BIT 7
`define IER_LOW_MASK 8'h0f
`define IER_HIGH_MASK 8'hf0

`define FCR_EN_BIT 0
`define FCR_RX_RST_BIT 1
`define FCR_TX_RST_BIT 2
`define FCR_TX_TRIG_LSB 4
`define FCR_TX_TRIG_MSB 5
`define FCR_RX_TRIG_LSB 6
`define FCR_RX_TRIG_MSB 7

`define FIFO_DEPTH 7'h40
`define RX_TRIG_0 7'h08
`define RX_TRIG_1 7'h10
`define RX_TRIG_2 7'h38
`define RX_TRIG_3 7'h3c
`define TX_TRIG_0 7'h08
`define TX_TRIG_1 7'h10
`define TX_TRIG_2 7'h20
`define TX_TRIG_3 7'h38
`define RX_TRIG_NOFIFO 7'h01

`define ID_LINE 6'h06
`define ID_TIMEOUT 6'h0c
`define ID_RX 6'h04
`define ID_TX 6'h02
`define ID_MODEM 6'h00
`define ID_PIN 6'h30
`define ID_XOFF 6'h10
`define ID_FLOW 6'h20

`define REF_CLK_HZ 40000000
`define FIFO_RST_REF_PERIODS 2
`define FIFO_RST_CYCLES 2'h2

`endif

/* File: tb/host_model.sv */
`timescale 1ns/10ps
`include "uart_irq_regs.vh"
module host_model (
    // Clock.
    input wire sys_clk,
    // Register port toward the device.
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released data is inverted so a stale byte is never mistaken for a fresh one.
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // One byte per strobe, never a burst on the identification place.
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // Status details of modem and pins come from their own registers.
    task settle;
        repeat (`FIFO_RST_CYCLES) @(negedge sys_clk);
    endtask
endmodule

/* File: tb/uart_fifo_irq_asserts.sv */
`timescale 1ns/10ps
`include "uart_irq_regs.vh"
module uart_fifo_irq_asserts (
    // Clock, reset and register port.
    input wire sys_clk,
    input wire nrst,
    input wire [3:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Condition and control signals.
    input wire enh_en,
    input wire line_err,
    input wire fifo_en,
    input wire rx_fifo_clr,
    input wire tx_fifo_clr,
    input wire [6:0] rx_trig_level,
    input wire [6:0] tx_trig_level,
    input wire [7:0] irq_enable_out,
    input wire irq_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_rx_clear_len: assert property (
        reg_wr && reg_addr == `ADDR_FIFO_CTRL && reg_wdata[1] |-> ##2 rx_fifo_clr [*2] ##1 !rx_fifo_clr)
        else $error("receive clear pulse wrong");
    a_tx_clear_len: assert property (
        reg_wr && reg_addr == `ADDR_FIFO_CTRL && reg_wdata[2] |-> ##2 tx_fifo_clr [*2] ##1 !tx_fifo_clr)
        else $error("transmit clear pulse wrong");
    a_ident_mirror: assert property (
        reg_rd && reg_addr == `ADDR_IRQ_IDENT |=> reg_rdata[7:6] == {2{fifo_en}})
        else $error("ident top bits differ from fifo enable");
    a_line_first: assert property (
        reg_rd && reg_addr == `ADDR_IRQ_IDENT && line_err ##1 irq_enable_out[2] |-> reg_rdata[5:0] == `ID_LINE)
        else $error("line error not shown first");
    a_line_irq: assert property (
        $past(line_err) && irq_enable_out[2] |-> !irq_n)
        else $error("request missing for line error");
    a_rx_trig_set: assert property (
        rx_trig_level inside {7'h01, 7'h08, 7'h10, 7'h38, 7'h3c})
        else $error("receive threshold illegal");
    a_tx_trig_set: assert property (
        tx_trig_level inside {7'h08, 7'h10, 7'h20, 7'h38, 7'h40})
        else $error("transmit threshold illegal");
    a_high_lock: assert property (
        !enh_en && reg_wr && reg_addr == `ADDR_IRQ_ENABLE |=> ##1 irq_enable_out[7:4] == $past(irq_enable_out[7:4]))
        else $error("upper enable bits changed while locked");
    a_low_write: assert property (
        reg_wr && reg_addr == `ADDR_IRQ_ENABLE |=> ##1 irq_enable_out[3:0] == $past(reg_wdata[3:0], 2))
        else $error("low enable bits not written");
    a_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule
bind uart_fifo_irq uart_fifo_irq_asserts chk_i (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enh_en(enh_en),
    .line_err(line_err), .fifo_en(fifo_en), .rx_fifo_clr(rx_fifo_clr), .tx_fifo_clr(tx_fifo_clr),
    .rx_trig_level(rx_trig_level), .tx_trig_level(tx_trig_level), .irq_enable_out(irq_enable_out), .irq_n(irq_n));

/* File: tb/uart_fifo_irq_test.sv */
`timescale 1ns/10ps
`include "uart_irq_regs.vh"
module uart_fifo_irq_test;
    logic sys_clk = 0, nrst = 0, enh_en = 0, tx_write = 0, fifo_en, irq_n, reg_wr, reg_rd, sleep_en, rx_clr, tx_clr;
    logic [6:0] rx_level = 0, tx_space = 0, src = 0, rx_trig_level, tx_trig_level;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, irq_enable_out, v;
    int errors = 0, checks = 0, interrupt_enable = 0, rxt = 8, txt = 8, txf = 0, fen = 0, i;
    int rt[4] = '{8, 16, 56, 60};
    int tt[4] = '{8, 16, 32, 56};
    always #12.5 sys_clk = ~sys_clk;
    host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    uart_fifo_irq dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enh_en(enh_en), .rx_level(rx_level), .tx_space(tx_space),
        .tx_write(tx_write), .line_err(src[6]), .rx_timeout(src[5]), .modem_event(src[4]), .pin_change(src[3]),
        .xoff_event(src[2]), .cts_event(src[1]), .rts_event(src[0]), .fifo_en(fifo_en), .rx_fifo_clr(rx_clr),
        .tx_fifo_clr(tx_clr), .rx_trig_level(rx_trig_level), .tx_trig_level(tx_trig_level), .sleep_en(sleep_en),
        .irq_enable_out(irq_enable_out), .irq_n(irq_n));
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Built from lowest priority upward so the highest pending source wins.
    function logic [7:0] ident();
        int c;
        c = 1;
        if ((src[0] && interrupt_enable[6]) || (src[1] && interrupt_enable[7])) c = 'h20;
        if (src[2] && interrupt_enable[5]) c = 'h10;
        if (src[3]) c = 'h30;
        if (src[4] && interrupt_enable[3]) c = 0;
        if (txf != 0) c = 2;
        if (rx_level >= rxt && rx_level != 0 && interrupt_enable[0]) c = 4;
        if (src[5] && interrupt_enable[0]) c = 'h0c;
        if (src[6] && interrupt_enable[2]) c = 6;
        return {{2{fen[0]}}, c[5:0]};
    endfunction
    task test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task wier(input logic [7:0] d);
        host.wr(`ADDR_IRQ_ENABLE, d);
        interrupt_enable = enh_en ? d : ((interrupt_enable & 'hf0) | (d & 'h0f));
        if (!d[1]) txf = 0;
        @(negedge sys_clk);
        chk("enable", interrupt_enable[7:0], irq_enable_out);
        chk("sleep", {7'h0, interrupt_enable[4]}, {7'h0, sleep_en});
    endtask
    task cid;
        host.rd(`ADDR_IRQ_IDENT, v);
        chk("ident", ident(), v);
        if (v[5:0] == 6'h02) txf = 0;
    endtask
    initial
    begin
        #(25 * 20000);
        errors++;
        test_done;
    end
    initial
    begin
        v = 8'($urandom(32'h8546deb5));
        repeat (10) @(negedge sys_clk);
        nrst = 1;
        chk("reset", 8'h00, {fifo_en, irq_enable_out[6:0]});
        chk("rxtrig", 8'h01, {1'b0, rx_trig_level});
        wier(8'hff);
        enh_en = 1;
        fen = 1;
        for (i = 0; i < 16; i++)
        begin
            host.wr(`ADDR_FIFO_CTRL, {i[3:0], 4'h1});
            rxt = rt[i / 4];
            txt = tt[i % 4];
            repeat (2) @(negedge sys_clk);
            chk("rxtrig", rxt[7:0], {1'b0, rx_trig_level});
            chk("txtrig", txt[7:0], {1'b0, tx_trig_level});
        end
        enh_en = 0;
        host.wr(`ADDR_FIFO_CTRL, 8'h07);
        host.settle;
        chk("clear", 8'h03, {6'h0, rx_clr, tx_clr});
        rxt = 8;
        chk("txtrig", txt[7:0], {1'b0, tx_trig_level});
        cid;
        chk("clear", 8'h00, {6'h0, rx_clr, tx_clr});
        host.rd(4'hf, v);
        chk("unmapped", 8'h00, v);
        enh_en = 1;
        wier(8'h02);
        tx_space = 7'h40;
        txf = 1;
        repeat (2) @(negedge sys_clk);
        chk("irq_n", 8'h00, {7'h0, irq_n});
        cid;
        cid;
        wier(8'h00);
        wier(8'h02);
        cid;
        tx_space = 0;
        @(negedge sys_clk);
        tx_space = 7'h40;
        repeat (2) @(negedge sys_clk);
        txf = 1;
        chk("irq_n", 8'h00, {7'h0, irq_n});
        tx_write = 1;
        @(negedge sys_clk);
        tx_write = 0;
        txf = 0;
        cid;
        chk("irq_n", 8'h01, {7'h0, irq_n});
        for (i = 0; i < 40; i++)
        begin
            wier(8'($urandom));
            src = 7'($urandom);
            rx_level = 7'($urandom_range(64));
            repeat (2) @(negedge sys_clk);
            chk("irq_n", {7'h0, ident() & 8'h01}, {7'h0, irq_n});
            cid;
        end
        host.wr(`ADDR_FIFO_CTRL, 8'h00);
        fen = 0;
        rxt = 1;
        repeat (2) @(negedge sys_clk);
        chk("rxtrig", 8'h01, {1'b0, rx_trig_level});
        chk("txtrig", 8'h40, {1'b0, tx_trig_level});
        chk("fifo_en", 8'h00, {7'h0, fifo_en});
        cid;
        test_done;
    end
endmodule
